// ==== design/acr_pkg.sv ====
/*
  acr_pkg: offsets, field positions and reset values of the converter
  configuration register slice.
  assumes: byte-wide registers on a plain address/strobe port.
*/
package acr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_REFERENCE_SOURCE = 8'h38;
  localparam logic [7:0] OFS_MARKER_INPUT     = 8'h3b;
  localparam logic [7:0] OFS_LANE_EMPHASIS    = 8'h48;
  localparam logic [7:0] OFS_PLL_PUMP         = 8'h4f;
  localparam logic [7:0] OFS_INPUT_SELECT     = 8'h60;
  localparam logic [7:0] OFS_CALIBRATION_RUN  = 8'h61;

  // reset values
  localparam logic [7:0] RST_REFERENCE_SOURCE = 8'h00;
  localparam logic [7:0] RST_MARKER_INPUT     = 8'h00;
  localparam logic [7:0] RST_LANE_EMPHASIS    = 8'h00;
  localparam logic [7:0] RST_PLL_PUMP         = 8'h13;
  localparam logic [7:0] RST_INPUT_SELECT     = 8'h01;
  localparam logic [7:0] RST_CALIBRATION_RUN  = 8'h01;

  // field positions
  localparam int BIT_REF_BYPASS    = 0;
  localparam int BIT_STAMP_RECV    = 0;
  localparam int BIT_STAMP_LVPECL  = 1;
  localparam int PE_LSB            = 0;
  localparam int PE_W              = 3;
  localparam int BIT_PE_BOOST      = 3;
  localparam int CP_LSB            = 0;
  localparam int CP_W              = 3;
  localparam int BIT_DUAL_SWAP     = 4;
  localparam int SRC_LSB           = 0;
  localparam int SRC_W             = 2;
  localparam int BIT_CAL_RUN       = 0;

  // single channel source codes
  localparam logic [1:0] SRC_RESERVED   = 2'h0;
  localparam logic [1:0] SRC_INPUT_A    = 2'h1;
  localparam logic [1:0] SRC_INPUT_B    = 2'h2;
  localparam logic [1:0] SRC_INTERLEAVE = 2'h3;

  localparam logic [7:0] READ_UNMAPPED  = 8'h00;
endpackage : acr_pkg

// ==== design/acr_cfg_reg.sv ====
/*
  acr_cfg_reg: one byte-wide read/write register with reset value.
  assumes: write strobe already decoded for this register.
*/
`timescale 1ns/1ps
`default_nettype none
module acr_cfg_reg #(
  parameter int         W       = 8,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // write side
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wdata_i,
  // stored value
  output logic      [W-1:0] q_o
);
  // reserved bits are kept too, they just steer nothing
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q_o <= RST_VAL[W-1:0];
    end else if (wr_i) begin
      q_o <= wdata_i;
    end
  end
endmodule : acr_cfg_reg
`default_nettype wire

// ==== design/acr_regs.sv ====
/*
  acr_regs: converter configuration register slice with decoded
  control outputs for reference, marker input, serializer, pll and
  input multiplexer, plus calibration run control.
  assumes: single clock, synchronous reset, plain strobe port master
  that never issues read and write in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module acr_regs
  import acr_pkg::*;
#(
  parameter int LANES = 16
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // device mode from the link setup
  input  wire logic              single_mode_i,
  // reference and marker input
  output logic                   reference_bypass_o,
  output logic                   stamp_receiver_enable_o,
  output logic                   stamp_lvpecl_select_o,
  // serializer lanes
  output logic [LANES*PE_W-1:0]  lane_preemphasis_o,
  output logic [LANES-1:0]       preemphasis_boost_o,
  // pll
  output logic [CP_W-1:0]        charge_pump_current_o,
  // applied input routing
  output logic                   dual_swap_o,
  output logic [SRC_W-1:0]       single_source_o,
  // calibration
  output logic                   cal_run_o,
  output logic                   cal_divider_reset_o
);

  typedef enum logic [1:0] {
    ACR_CAL_HOLD = 2'b01,
    ACR_CAL_RUN  = 2'b10
  } acr_cal_state_t;

  logic [DATA_W-1:0] ref_q;
  logic [DATA_W-1:0] mark_q;
  logic [DATA_W-1:0] pe_q;
  logic [DATA_W-1:0] cp_q;
  logic [DATA_W-1:0] mux_q;
  logic [DATA_W-1:0] cal_q;
  logic [DATA_W-1:0] next_rdata;
  acr_cal_state_t    cal_state;
  acr_cal_state_t    next_cal_state;

  // one storage register per offset
  acr_cfg_reg #(.W(DATA_W), .RST_VAL(RST_REFERENCE_SOURCE)) u_ref (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_i && addr_i == OFS_REFERENCE_SOURCE),
    .wdata_i   (wdata_i),
    .q_o       (ref_q)
  );
  acr_cfg_reg #(.W(DATA_W), .RST_VAL(RST_MARKER_INPUT)) u_mark (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_i && addr_i == OFS_MARKER_INPUT),
    .wdata_i   (wdata_i),
    .q_o       (mark_q)
  );
  acr_cfg_reg #(.W(DATA_W), .RST_VAL(RST_LANE_EMPHASIS)) u_pe (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_i && addr_i == OFS_LANE_EMPHASIS),
    .wdata_i   (wdata_i),
    .q_o       (pe_q)
  );
  acr_cfg_reg #(.W(DATA_W), .RST_VAL(RST_PLL_PUMP)) u_cp (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_i && addr_i == OFS_PLL_PUMP),
    .wdata_i   (wdata_i),
    .q_o       (cp_q)
  );
  acr_cfg_reg #(.W(DATA_W), .RST_VAL(RST_INPUT_SELECT)) u_mux (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_i && addr_i == OFS_INPUT_SELECT),
    .wdata_i   (wdata_i),
    .q_o       (mux_q)
  );
  acr_cfg_reg #(.W(DATA_W), .RST_VAL(RST_CALIBRATION_RUN)) u_cal (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_i && addr_i == OFS_CALIBRATION_RUN),
    .wdata_i   (wdata_i),
    .q_o       (cal_q)
  );

  // read mux, answer the cycle after the strobe only
  always_comb begin
    next_rdata = READ_UNMAPPED;
    if (rd_i) begin
      case (addr_i)
        OFS_REFERENCE_SOURCE: next_rdata = ref_q;
        OFS_MARKER_INPUT:     next_rdata = mark_q;
        OFS_LANE_EMPHASIS:    next_rdata = pe_q;
        OFS_PLL_PUMP:         next_rdata = cp_q;
        OFS_INPUT_SELECT:     next_rdata = mux_q;
        OFS_CALIBRATION_RUN:  next_rdata = cal_q;
        default:              next_rdata = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= READ_UNMAPPED;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // reference and marker controls
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reference_bypass_o      <= RST_REFERENCE_SOURCE[BIT_REF_BYPASS];
      stamp_receiver_enable_o <= RST_MARKER_INPUT[BIT_STAMP_RECV];
      stamp_lvpecl_select_o   <= RST_MARKER_INPUT[BIT_STAMP_LVPECL];
    end else begin
      reference_bypass_o      <= ref_q[BIT_REF_BYPASS];
      stamp_receiver_enable_o <= mark_q[BIT_STAMP_RECV];
      // lvpecl select only matters once the receiver is on
      stamp_lvpecl_select_o   <= mark_q[BIT_STAMP_LVPECL];
    end
  end

  // serializer and pll, one common setting fanned to every lane
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lane_preemphasis_o    <= {LANES{RST_LANE_EMPHASIS[PE_LSB +: PE_W]}};
      preemphasis_boost_o   <= {LANES{RST_LANE_EMPHASIS[BIT_PE_BOOST]}};
      charge_pump_current_o <= RST_PLL_PUMP[CP_LSB +: CP_W];
    end else begin
      lane_preemphasis_o    <= {LANES{pe_q[PE_LSB +: PE_W]}};
      preemphasis_boost_o   <= {LANES{pe_q[BIT_PE_BOOST]}};
      // maximum code is the overrange setting software may pick
      charge_pump_current_o <= cp_q[CP_LSB +: CP_W];
    end
  end

  // calibration run control
  always_comb begin
    next_cal_state = cal_state;
    case (cal_state)
      ACR_CAL_HOLD: begin
        if (cal_q[BIT_CAL_RUN]) begin
          next_cal_state = ACR_CAL_RUN;
        end
      end
      ACR_CAL_RUN: begin
        if (!cal_q[BIT_CAL_RUN]) begin
          next_cal_state = ACR_CAL_HOLD;
        end
      end
      default: next_cal_state = ACR_CAL_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cal_state           <= ACR_CAL_RUN;
      cal_run_o           <= RST_CALIBRATION_RUN[BIT_CAL_RUN];
      cal_divider_reset_o <= ~RST_CALIBRATION_RUN[BIT_CAL_RUN];
    end else begin
      cal_state           <= next_cal_state;
      cal_run_o           <= (next_cal_state == ACR_CAL_RUN);
      cal_divider_reset_o <= (next_cal_state == ACR_CAL_HOLD);
    end
  end

  // routing is latched only when a calibration starts, so a mux write
  // during a run changes nothing until software recalibrates
  logic cal_start;
  assign cal_start = (cal_state == ACR_CAL_HOLD) &&
                     (next_cal_state == ACR_CAL_RUN);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dual_swap_o     <= RST_INPUT_SELECT[BIT_DUAL_SWAP];
      single_source_o <= RST_INPUT_SELECT[SRC_LSB +: SRC_W];
    end else if (cal_start) begin
      // each field applies only in its own kind of mode
      if (!single_mode_i) begin
        dual_swap_o <= mux_q[BIT_DUAL_SWAP];
      end
      if (single_mode_i) begin
        single_source_o <= mux_q[SRC_LSB +: SRC_W];
      end
    end
  end

  // assertions
  property p_ref_bypass;
    @(posedge sys_clk_i) disable iff (rst_i)
      reference_bypass_o == $past(ref_q[BIT_REF_BYPASS]);
  endproperty
  a_ref_bypass: assert property (p_ref_bypass)
    else $error("reference bypass output wrong");

  property p_stamp;
    @(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && addr_i == OFS_MARKER_INPUT) |-> ##2
        stamp_receiver_enable_o == $past(wdata_i[BIT_STAMP_RECV], 2) &&
        stamp_lvpecl_select_o == $past(wdata_i[BIT_STAMP_LVPECL], 2);
  endproperty
  a_stamp: assert property (p_stamp)
    else $error("marker controls do not follow write");

  property p_lanes;
    @(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && addr_i == OFS_LANE_EMPHASIS) |-> ##2
        lane_preemphasis_o[(LANES-1)*PE_W +: PE_W] ==
          $past(wdata_i[PE_LSB +: PE_W], 2) &&
        preemphasis_boost_o[LANES-1] == $past(wdata_i[BIT_PE_BOOST], 2);
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("lane emphasis not applied");

  property p_pump;
    @(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && addr_i == OFS_PLL_PUMP) |-> ##2
        charge_pump_current_o == $past(wdata_i[CP_LSB +: CP_W], 2);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump current not applied");

  property p_route_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      !$past(cal_start) |-> $stable(dual_swap_o) && $stable(single_source_o);
  endproperty
  a_route_hold: assert property (p_route_hold)
    else $error("routing changed without calibration");

  property p_swap_single;
    @(posedge sys_clk_i) disable iff (rst_i)
      single_mode_i |=> $stable(dual_swap_o);
  endproperty
  a_swap_single: assert property (p_swap_single)
    else $error("swap changed in single mode");

  property p_src_dual;
    @(posedge sys_clk_i) disable iff (rst_i)
      !single_mode_i |=> $stable(single_source_o);
  endproperty
  a_src_dual: assert property (p_src_dual)
    else $error("source changed in dual mode");

  property p_cal;
    @(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && addr_i == OFS_CALIBRATION_RUN) |-> ##2
        cal_run_o == $past(wdata_i[BIT_CAL_RUN], 2) &&
        cal_divider_reset_o == !cal_run_o;
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration run not following enable");

  property p_read_back;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rd_i && addr_i == OFS_PLL_PUMP && !wr_i) |=> rdata_o == cp_q;
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data wrong");

  // read data must fall back to zero, or a stale byte could be taken
  property p_rdata_idle;
    @(posedge sys_clk_i) disable iff (rst_i)
      !rd_i |=> rdata_o == READ_UNMAPPED;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared after read");

  // every lane carries the same copy, not only the top one
  property p_lane_copies;
    @(posedge sys_clk_i) disable iff (rst_i)
      lane_preemphasis_o == {LANES{lane_preemphasis_o[PE_W-1:0]}} &&
      preemphasis_boost_o == {LANES{preemphasis_boost_o[0]}};
  endproperty
  a_lane_copies: assert property (p_lane_copies)
    else $error("lanes disagree on pre-emphasis");

  property p_div_follows_run;
    @(posedge sys_clk_i) disable iff (rst_i)
      cal_divider_reset_o == !cal_run_o;
  endproperty
  a_div_follows_run: assert property (p_div_follows_run)
    else $error("divider reset not opposite to calibration run");

  property p_swap_applied;
    @(posedge sys_clk_i) disable iff (rst_i)
      (cal_start && !single_mode_i) |=>
        dual_swap_o == $past(mux_q[BIT_DUAL_SWAP]);
  endproperty
  a_swap_applied: assert property (p_swap_applied)
    else $error("swap not taken at calibration start");

  property p_src_applied;
    @(posedge sys_clk_i) disable iff (rst_i)
      (cal_start && single_mode_i) |=>
        single_source_o == $past(mux_q[SRC_LSB +: SRC_W]);
  endproperty
  a_src_applied: assert property (p_src_applied)
    else $error("source not taken at calibration start");

  // no disable here: this one exists to watch the reset itself
  property p_reset_values;
    @(posedge sys_clk_i)
      rst_i |=> cal_run_o == RST_CALIBRATION_RUN[BIT_CAL_RUN] &&
        charge_pump_current_o == RST_PLL_PUMP[CP_LSB +: CP_W] &&
        single_source_o == RST_INPUT_SELECT[SRC_LSB +: SRC_W] &&
        rdata_o == READ_UNMAPPED;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("outputs not at reset values");

  c_cal_restart: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    cal_start);
  c_swap: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(dual_swap_o));
  c_interleave: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    single_source_o == SRC_INTERLEAVE);
  c_pump_max: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    charge_pump_current_o == 3'h7);

endmodule : acr_regs
`default_nettype wire

// ==== testbench/tb_acr_regs.sv ====
/*
  tb_acr_regs: self-checking bench for the converter configuration
  register slice, one task per scenario.
  assumes: acr_pkg and acr_regs compiled first; one 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("BAD %s exp %h got %h", nm, exp, got); \
    end \
  end
module tb_acr_regs
  import acr_pkg::*;
;
  logic              sys_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [7:0]        addr_i = 8'h00;
  logic [7:0]        wdata_i = 8'h00;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic              single_mode_i = 1'b0;
  logic [7:0]        rdata_o;
  logic              ref_o;
  logic              recv_o;
  logic              lvpecl_o;
  logic [47:0]       pe_o;
  logic [15:0]       boost_o;
  logic [2:0]        cp_o;
  logic              swap_o;
  logic [1:0]        src_o;
  logic              cal_o;
  logic              div_o;
  int                err_total = 0;
  int                check_count = 0;
  logic              cur_swap;
  logic [1:0]        cur_src;
  logic [7:0]        ofs [6] = '{OFS_REFERENCE_SOURCE, OFS_MARKER_INPUT,
    OFS_LANE_EMPHASIS, OFS_PLL_PUMP, OFS_INPUT_SELECT, OFS_CALIBRATION_RUN};
  logic [7:0]        rst [6] = '{RST_REFERENCE_SOURCE, RST_MARKER_INPUT,
    RST_LANE_EMPHASIS, RST_PLL_PUMP, RST_INPUT_SELECT, RST_CALIBRATION_RUN};

  acr_regs DUT (
    .sys_clk_i               (sys_clk_i),
    .rst_i                   (rst_i),
    .addr_i                  (addr_i),
    .wdata_i                 (wdata_i),
    .wr_i                    (wr_i),
    .rd_i                    (rd_i),
    .rdata_o                 (rdata_o),
    .single_mode_i           (single_mode_i),
    .reference_bypass_o      (ref_o),
    .stamp_receiver_enable_o (recv_o),
    .stamp_lvpecl_select_o   (lvpecl_o),
    .lane_preemphasis_o      (pe_o),
    .preemphasis_boost_o     (boost_o),
    .charge_pump_current_o   (cp_o),
    .dual_swap_o             (swap_o),
    .single_source_o         (src_o),
    .cal_run_o               (cal_o),
    .cal_divider_reset_o     (div_o)
  );

  always #2.5 sys_clk_i = ~sys_clk_i;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // controls land one edge after the register itself
  task automatic settle();
    @(posedge sys_clk_i);
    #1;
  endtask : settle

  task automatic t_reset_vals();
    logic [7:0] d;
    settle();
    `CHK("ref", 1'b0, ref_o)
    `CHK("recv", 1'b0, recv_o)
    `CHK("lvpecl", 1'b0, lvpecl_o)
    `CHK("pe", 48'h0, pe_o)
    `CHK("boost", 16'h0, boost_o)
    `CHK("cp", 3'h3, cp_o)
    `CHK("swap", 1'b0, swap_o)
    `CHK("src", SRC_INPUT_A, src_o)
    `CHK("cal", 1'b1, cal_o)
    `CHK("div", 1'b0, div_o)
    `CHK("rdata", READ_UNMAPPED, rdata_o)
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], d);
      `CHK("reset read", rst[i], d)
    end
    cur_swap = 1'b0;
    cur_src = SRC_INPUT_A;
  endtask : t_reset_vals

  task automatic t_readback();
    logic [7:0] d;
    for (int i = 0; i < 6; i++) wr(ofs[i], 8'hff);
    wr(8'h39, 8'hff);
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], d);
      `CHK("rw read", 8'hff, d)
    end
    // last read returned 0xff, so a stale byte would show here
    settle();
    `CHK("rdata idle", READ_UNMAPPED, rdata_o)
    rd(8'h39, d);
    `CHK("unmapped", READ_UNMAPPED, d)
    `CHK("ref on", 1'b1, ref_o)
    `CHK("cp max", 3'h7, cp_o)
    `CHK("swap held", cur_swap, swap_o)
    `CHK("src held", cur_src, src_o)
    wr(OFS_MARKER_INPUT, 8'h02);
    settle();
    `CHK("recv off", 1'b0, recv_o)
    `CHK("lvpecl", 1'b1, lvpecl_o)
    wr(OFS_MARKER_INPUT, 8'h01);
    settle();
    `CHK("recv on", 1'b1, recv_o)
    `CHK("lvpecl off", 1'b0, lvpecl_o)
  endtask : t_readback

  task automatic t_pump_emph();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      // last pass leaves the maximum code, the overrange setting
      wr(OFS_PLL_PUMP, {5'h02, c});
      wr(OFS_LANE_EMPHASIS, {4'h0, c[0], c});
      settle();
      `CHK("cp", c, cp_o)
      `CHK("pe", {16{c}}, pe_o)
      `CHK("boost", {16{c[0]}}, boost_o)
    end
  endtask : t_pump_emph

  // mux write, then hold calibration and rerun it
  task automatic t_recal(input logic s, input logic [7:0] v);
    @(posedge sys_clk_i);
    single_mode_i <= s;
    wr(OFS_INPUT_SELECT, v);
    settle();
    `CHK("swap early", cur_swap, swap_o)
    `CHK("src early", cur_src, src_o)
    // no link enable here, so clearing calibration is always legal
    wr(OFS_CALIBRATION_RUN, 8'h00);
    settle();
    `CHK("cal hold", 1'b0, cal_o)
    `CHK("div hold", 1'b1, div_o)
    wr(OFS_CALIBRATION_RUN, 8'h01);
    settle();
    `CHK("cal run", 1'b1, cal_o)
    `CHK("div run", 1'b0, div_o)
    if (s) cur_src = v[1:0];
    else cur_swap = v[4];
    `CHK("swap", cur_swap, swap_o)
    `CHK("src", cur_src, src_o)
  endtask : t_recal

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial begin
    #50000;
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset_vals();
    t_readback();
    t_pump_emph();
    t_recal(1'b0, 8'h13);
    t_recal(1'b1, 8'h02);
    t_recal(1'b1, 8'h03);
    t_recal(1'b0, 8'h00);
    t_recal(1'b1, 8'h10);
    t_recal(1'b1, 8'h01);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset_vals();
    wrap_up();
  end
endmodule : tb_acr_regs
`default_nettype wire
